//--- design/vpgst_top.sv
/*
  Test section of a serial video transmitter: lock indication, output
  gating, power-on reset, full-field pattern generator and go/no-go
  self-test, plus an APB register slave.
  Assumes the word clock clk is the only clock, that an analog loop
  reports its lock on pllLocked and shifts wordOut out at ten times the
  word rate, LSB first, and that pads add pull-downs to all inputs.
*/
// Behaviour
// R1: Serial bit clock is ten times word clock.
// R2: Lock output high exactly while loop locked; the code lags pllLocked by one word clock.
// R3: Serial output static while out of lock.
// R4: Power-on reset clears all state, disables output.
// R5: Both serial lines high impedance during reset.
// R6: Reset holds until the word clock runs.
// R7: Start word clock 30 us after supply.
// R8: Self-test runs pattern through datapath, checks errors.
// R9: Self-test uses colour bars or PLL pathological.
// R10: Operator sets code, waits lock, raises enable.
// R11: Pass rises about two fields after enable.
// R12: Detected error keeps pass output low.
// R13: Enable low ends self-test mode.
// R14: Serial stream continues during self-test.
// R15: Undriven data inputs read as zero.
// R16: Operator supplies 27 or 36 MHz clock.
// R17: Enabled generator sends selected pattern serially.
// R18: Enable low returns to normal serialization.
// R19: Code bits pick raster, standard, pattern; the code ignores CODE_STD_BIT.
// R20: Black, PLL, EQ and 75% eight-bar patterns.
// R21: Colour bars switch abruptly, no band-limiting.
// R22: Enable may be tied to lock output.
// R23: Code held stable while enable high.
module vpgst_top import vpgst_pkg::*; #(
  parameter int LINE_WORDS_43 = 1716,
  parameter int LINE_WORDS_169 = 2288,
  parameter int BAR_WORDS_43 = 180,
  parameter int BAR_WORDS_169 = 240,
  parameter int FIELD_LINES = 263
) (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Parallel video word and pattern control pins.
  input wire logic [9:0] dataIn,
  input wire logic patternGenEnablePin,
  // Lock report of the analog clock multiplier.
  input wire logic pllLocked,
  // Word handed to the ten-times shifter and its drive control.
  output logic [9:0] wordOut,
  output logic serialOutEn_n,
  // Lock indicator and self-test result.
  output logic lockDetect,
  output logic testOut,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Bars alone must fit within a line; the counters need some width.
  generate
    if (LINE_WORDS_43 < 8 * BAR_WORDS_43 || LINE_WORDS_169 < 8 * BAR_WORDS_169
        || BAR_WORDS_43 < 1 || BAR_WORDS_169 < 1 || FIELD_LINES < 2
        || LINE_WORDS_169 > 4095 || LINE_WORDS_43 > 4095
        || FIELD_LINES > 4095) begin : g_bad_params
      $error("vpgst_top: raster parameters out of range.");
    end
  endgenerate

  // 75% bar words, luma and two chroma, from white to black.
  localparam logic [9:0] BAR_Y [8] = '{10'h2D0, 10'h274, 10'h224,
    10'h1C4, 10'h15C, 10'h0FC, 10'h0AC, 10'h040};
  localparam logic [9:0] BAR_CB [8] = '{10'h200, 10'h0B0, 10'h26C,
    10'h11C, 10'h2E4, 10'h194, 10'h350, 10'h200};
  localparam logic [9:0] BAR_CR [8] = '{10'h200, 10'h22C, 10'h0B0,
    10'h0DC, 10'h324, 10'h350, 10'h1D4, 10'h200};

  // Scrambles one word with x^9+x^4+1 and codes it NRZI, LSB first.
  function automatic vpgst_coder_t encodeWord(input logic [9:0] d,
      input logic [8:0] sr, input logic lvl);
    vpgst_coder_t r;
    logic s;
    r.shift = sr;
    r.level = lvl;
    r.word = '0;
    for (int i = 0; i < 10; i++) begin
      s = d[i] ^ r.shift[8] ^ r.shift[3];
      r.shift = {r.shift[7:0], s};
      r.level = r.level ^ s;
      r.word[i] = r.level;
    end
    return r;
  endfunction : encodeWord

  // Undoes the line code and the scrambling, as a receiver would.
  function automatic vpgst_coder_t decodeWord(input logic [9:0] n,
      input logic [8:0] sr, input logic lvl);
    vpgst_coder_t r;
    logic s;
    r.shift = sr;
    r.level = lvl;
    r.word = '0;
    for (int i = 0; i < 10; i++) begin
      s = n[i] ^ r.level;
      r.level = n[i];
      r.word[i] = s ^ r.shift[8] ^ r.shift[3];
      r.shift = {r.shift[7:0], s};
    end
    return r;
  endfunction : decodeWord

  // Control register, mode and captured pattern code.
  logic [31:0] ctrl;
  vpgst_mode_t mode;
  logic [3:0] code;
  // Raster position counters and self-test bookkeeping.
  logic [11:0] sampleCnt;
  logic [11:0] lineCnt;
  logic [11:0] barCnt;
  logic [2:0] barIdx;
  logic [1:0] fieldCnt;
  logic testError;
  // Coder state of the sending and of the checking side.
  logic [8:0] txShift;
  logic txLevel;
  logic [8:0] rxShift;
  logic rxLevel;
  // Set once the first word clock after reset has been seen.
  logic started;

  // Effective enable from the pin or from software.
  wire logic enable = patternGenEnablePin | ctrl[CTRL_SW_EN_BIT];
  // The pads pull undriven data inputs to zero, so the code is clean.
  wire logic [3:0] liveCode = ctrl[CTRL_CODE_SEL_BIT] ? // see R15
    ctrl[CTRL_CODE_LSB +: 4] : dataIn[3:0];
  wire logic isTest = (liveCode == CODE_TEST_BARS) // see R9
    || (liveCode == CODE_TEST_PLL);
  wire logic wide = code[CODE_RASTER_BIT]; // see R19
  wire logic [11:0] lineLast = wide ? 12'(LINE_WORDS_169 - 1)
    : 12'(LINE_WORDS_43 - 1);
  wire logic [11:0] barLast = wide ? 12'(BAR_WORDS_169 - 1)
    : 12'(BAR_WORDS_43 - 1);
  wire logic lineEnd = (sampleCnt == lineLast);
  wire logic fieldEnd = lineEnd && (lineCnt == 12'(FIELD_LINES - 1));
  wire logic inBars = (sampleCnt < 12'(8) * (barLast + 12'h001));
  wire logic active = (mode != MODE_NORMAL);

  // Chroma on even samples, Cb and Cr alternating; luma on odd samples.
  wire logic isLuma = sampleCnt[0];
  wire logic isCr = sampleCnt[1];
  wire logic [9:0] barWord = isLuma ? BAR_Y[barIdx]
    : (isCr ? BAR_CR[barIdx] : BAR_CB[barIdx]);
  // Bars change value on a single word, with no filtering.
  wire logic [9:0] patWord = // see R20, R21
    (code[1:0] == PAT_PLL) ? (isLuma ? PLL_Y : PLL_C) :
    (code[1:0] == PAT_EQ) ? (isLuma ? EQ_Y : EQ_C) :
    (code[1:0] == PAT_BARS && inBars) ? barWord :
    (isLuma ? BLACK_Y : BLACK_C);
  // The generated word replaces the input word in the data path.
  wire logic [9:0] srcWord = active ? patWord : dataIn; // see R8, R17

  // Coding and checking of the current word.
  wire vpgst_coder_t txNext = encodeWord(srcWord, txShift, txLevel);
  wire vpgst_coder_t rxNext = decodeWord(txNext.word, rxShift, rxLevel);
  wire logic wordBad = (rxNext.word != srcWord);

  // APB decode; the slave always answers in the access cycle.
  wire logic apbAccess = psel && penable;
  wire logic hitCtrl = (paddr == REG_CTRL);
  wire logic hitStatus = (paddr == REG_STATUS);
  wire logic apbWrCtrl = apbAccess && pwrite && hitCtrl;
  vpgst_status_t status;

  // Status word built from live state.
  always_comb begin
    status = '0;
    status.fieldCount = fieldCnt;
    status.mode = mode;
    status.patternActive = active;
    status.selfTestError = testError;
    status.selfTestPass = testOut;
    status.outputEnabled = ~serialOutEn_n;
    status.locked = lockDetect;
  end

  assign pready = 1'b1;
  assign pslverr = apbAccess && !hitCtrl && !hitStatus;
  assign prdata = !apbAccess || pwrite ? 32'h0000_0000 :
    hitCtrl ? ctrl : hitStatus ? 32'(status) : 32'h0000_0000;

  // Control register; only mapped bits are kept.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
    end else if (clkEn && apbWrCtrl) begin
      ctrl <= {26'h000_0000, pwdata[5:0]};
    end
  end

  // Reset is synchronous, so nothing leaves it before the clock runs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      started <= 1'b0; // see R4, R6
    end else if (clkEn) begin
      started <= 1'b1; // see R6
    end
  end

  // Lock indicator follows the loop, one word clock later.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockDetect <= 1'b0;
    end else if (clkEn) begin
      lockDetect <= pllLocked; // see R2
    end
  end

  // Mode changes; the code is caught when the enable is first seen with lock.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= MODE_NORMAL;
      code <= 4'h0;
    end else if (clkEn) begin
      case (mode)
        MODE_NORMAL: begin
          if (enable && lockDetect) begin
            code <= liveCode; // see R19
            mode <= isTest ? MODE_SELFTEST : MODE_PATTERN; // see R8
          end
        end
        MODE_PATTERN, MODE_SELFTEST: begin
          if (!enable) begin
            mode <= MODE_NORMAL; // see R13, R18
          end
        end
        default: begin
          mode <= MODE_NORMAL;
        end
      endcase
    end
  end

  // Raster counters advance only while a pattern runs.
  always_ff @(posedge clk) begin
    if (!rst_n || (clkEn && !active)) begin
      sampleCnt <= 12'h000;
      lineCnt <= 12'h000;
      barCnt <= 12'h000;
      barIdx <= 3'h0;
    end else if (clkEn) begin
      sampleCnt <= lineEnd ? 12'h000 : sampleCnt + 12'h001;
      lineCnt <= fieldEnd ? 12'h000 : lineCnt + 12'(lineEnd);
      barCnt <= (lineEnd || barCnt == barLast) ? 12'h000
        : barCnt + 12'h001;
      barIdx <= lineEnd ? 3'h0 : barIdx + 3'(barCnt == barLast);
    end
  end

  // Self-test counts fields and keeps any mismatch until it ends.
  always_ff @(posedge clk) begin
    if (!rst_n || (clkEn && mode != MODE_SELFTEST)) begin
      fieldCnt <= 2'h0;
      testError <= 1'b0;
      testOut <= 1'b0;
    end else if (clkEn) begin
      if (fieldEnd && fieldCnt != PASS_FIELDS) begin
        fieldCnt <= fieldCnt + 2'h1; // see R11
      end
      // A lost lock is an internal fault as well.
      testError <= testError | wordBad | !lockDetect; // see R12
      // A lock loss in the same cycle must not let a pass slip out.
      testOut <= (fieldCnt == PASS_FIELDS) && !testError // see R11, R12
        && !wordBad && lockDetect;
    end
  end

  // Coders run on every word; the checker mirrors the sender.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txShift <= 9'h000; // see R4
      txLevel <= 1'b0;
      rxShift <= 9'h000;
      rxLevel <= 1'b0;
    end else if (clkEn) begin
      txShift <= txNext.shift;
      txLevel <= txNext.level;
      rxShift <= rxNext.shift;
      rxLevel <= rxNext.level;
    end
  end

  // Output word. Out of lock the line sits at its last level, since a
  // word clock alone cannot space bits evenly without the loop.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wordOut <= 10'h000;
      serialOutEn_n <= 1'b1; // see R5
    end else if (clkEn) begin
      serialOutEn_n <= !started; // see R4, R6
      if (lockDetect) begin
        wordOut <= txNext.word; // see R1, R14, R17
      end else begin
        wordOut <= {10{wordOut[9]}}; // see R3
      end
    end
  end

  // Lock output is the loop report one edge later.
  a_lock_follow: assert property ( // see R2
    @(posedge clk) disable iff (!rst_n)
    clkEn |=> lockDetect == $past(pllLocked))
    else $error("Lock output does not follow the loop.");

  // Without lock the word carries no transitions.
  a_static_unlock: assert property ( // see R3
    @(posedge clk) disable iff (!rst_n)
    clkEn && !lockDetect |=> wordOut == {10{$past(wordOut[9])}})
    else $error("Serial word toggles while out of lock.");

  // The drive stays off through reset and its first release edge.
  a_reset_off: assert property ( // see R5
    @(posedge clk)
    !rst_n |=> serialOutEn_n && wordOut == 10'h000)
    else $error("Output driven during reset.");

  // The self-test mode is entered only for the two test codes.
  a_test_code: assert property ( // see R9
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_SELFTEST |-> code == CODE_TEST_BARS
      || code == CODE_TEST_PLL)
    else $error("Self-test runs with a non-test code.");

  // A pass needs two full fields in self-test.
  a_pass_late: assert property ( // see R11
    @(posedge clk) disable iff (!rst_n)
    $rose(testOut) |-> $past(fieldCnt) == PASS_FIELDS
      && $past(mode) == MODE_SELFTEST)
    else $error("Pass reported before two fields.");

  // Once an error is seen, the pass output stays low.
  a_error_low: assert property ( // see R12
    @(posedge clk) disable iff (!rst_n)
    testError && mode == MODE_SELFTEST |-> !testOut)
    else $error("Pass output high after an error.");

  // Dropping the enable leaves any pattern mode on the next edge.
  a_enable_exit: assert property ( // see R13, R18
    @(posedge clk) disable iff (!rst_n)
    clkEn && !enable && active |=> mode == MODE_NORMAL ##1 !testOut)
    else $error("Mode kept after enable fell.");

  // In lock the stream keeps flowing during the self-test.
  a_stream_on: assert property ( // see R14
    @(posedge clk) disable iff (!rst_n)
    mode == MODE_SELFTEST && started |-> !serialOutEn_n)
    else $error("Serial output stopped during self-test.");

  // The checker recovers every word the sender coded.
  a_path_clean: assert property ( // see R8
    @(posedge clk) disable iff (!rst_n)
    $past(clkEn) && $past(rst_n) |-> rxNext.word == srcWord)
    else $error("Data path corrupts a word.");

endmodule : vpgst_top

//--- design/vpgst_pkg.sv
/*
  Shared constants and types of the video pattern generator and self-test
  block: register offsets, field layouts, pattern codes and video words.
  Assumes a single parallel word clock and a 10-bit video word.
*/
package vpgst_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  // Control register fields and reset value.
  localparam int CTRL_SW_EN_BIT = 0;
  localparam int CTRL_CODE_SEL_BIT = 1;
  localparam int CTRL_CODE_LSB = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Pattern code fields: raster, standard, pattern kind.
  localparam int CODE_RASTER_BIT = 3;
  localparam int CODE_STD_BIT = 2;
  localparam logic [1:0] PAT_BLACK = 2'h0;
  localparam logic [1:0] PAT_PLL = 2'h1;
  localparam logic [1:0] PAT_EQ = 2'h2;
  localparam logic [1:0] PAT_BARS = 2'h3;
  localparam logic [3:0] CODE_TEST_BARS = 4'h3;
  localparam logic [3:0] CODE_TEST_PLL = 4'h5;

  // Flat-field and pathological word pairs (chroma, luma).
  localparam logic [9:0] BLACK_C = 10'h200;
  localparam logic [9:0] BLACK_Y = 10'h040;
  localparam logic [9:0] PLL_C = 10'h200;
  localparam logic [9:0] PLL_Y = 10'h110;
  localparam logic [9:0] EQ_C = 10'h300;
  localparam logic [9:0] EQ_Y = 10'h198;

  // Number of fields a clean self-test runs before it reports a pass.
  localparam logic [1:0] PASS_FIELDS = 2'h2;

  // Operating mode of the word path.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PATTERN = 2'b01,
    MODE_SELFTEST = 2'b10
  } vpgst_mode_t;

  // Status word as software sees it.
  typedef struct packed {
    logic [22:0] zero;
    logic [1:0] fieldCount;
    logic [1:0] mode;
    logic patternActive;
    logic selfTestError;
    logic selfTestPass;
    logic outputEnabled;
    logic locked;
  } vpgst_status_t;

  // State carried by the scrambler and line coder across words.
  typedef struct packed {
    logic [9:0] word;
    logic [8:0] shift;
    logic level;
  } vpgst_coder_t;

endpackage : vpgst_pkg

//--- verif/vpgst_rx_model.sv
/*
  Far-side model: a serial video receiver watching the coded word stream.
  Assumes the shifter sends each word of wordOut whole, one word a clock.
*/
module vpgst_rx_model (
  // Clock and reset of the word domain.
  input wire logic clk,
  input wire logic rst_n,
  // Coded stream and driver enable seen on the cable side.
  input wire logic [9:0] wordOut,
  input wire logic serialOutEn_n,
  // Count of word changes and the floating-line flag.
  output logic [15:0] changeCount,
  output logic lineFloat
);
  timeunit 1ns;
  timeprecision 1ps;

  // Last word received, to spot transitions on the line.
  logic [9:0] prevWord;

  // Undriven lines float; the receiver only sees its own termination.
  assign lineFloat = serialOutEn_n;

  // Count changes only while driven, since a floating line is noise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      changeCount <= 16'h0000;
      prevWord <= 10'h000;
    end else begin
      prevWord <= wordOut;
      if (!serialOutEn_n && wordOut !== prevWord) begin
        changeCount <= changeCount + 16'h0001;
      end
    end
  end
endmodule : vpgst_rx_model

//--- verif/vpgst_top_tb.sv
/*
  Self-checking bench of the pattern generator and self-test block.
  Assumes shortened field counts and a zero-wait APB slave.
*/
module vpgst_top_tb import vpgst_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // Words in one shortened field: lines times words per line.
  localparam int FIELD_WORDS = 3 * 40;

  logic clk, rst_n, clkEn, patternGenEnablePin, pllLocked;
  logic [9:0] dataIn, wordOut;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic serialOutEn_n, lockDetect, testOut, err, lineFloat;
  logic [15:0] changeCount;
  vpgst_status_t st;
  int fails = 0;
  int samplesChecked = 0;

  vpgst_top #(.LINE_WORDS_43(40), .LINE_WORDS_169(48), .BAR_WORDS_43(4),
    .BAR_WORDS_169(5), .FIELD_LINES(3)) vpgst_top_i (.clk(clk),
    .rst_n(rst_n), .clkEn(clkEn), .dataIn(dataIn),
    .patternGenEnablePin(patternGenEnablePin), .pllLocked(pllLocked),
    .wordOut(wordOut), .serialOutEn_n(serialOutEn_n),
    .lockDetect(lockDetect), .testOut(testOut), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  vpgst_rx_model vpgst_rx_model_i (.clk(clk), .rst_n(rst_n),
    .wordOut(wordOut), .serialOutEn_n(serialOutEn_n),
    .changeCount(changeCount), .lineFloat(lineFloat));

  // Word clock at 25 MHz; the bench itself raises and drops pllLocked.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compares one result; four-state inequality lets no unknown pass.
  task check(input string name, input logic [31:0] exp,
             input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Automatic, since the watchdog and the main sequence wait at once.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One APB transfer; the request is held until pready is sampled high.
  // An idle edge follows, so a second call never reassigns psel at once.
  task apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rd_status;
    apb(REG_STATUS, 1'b0, 32'h0000_0000);
    st = vpgst_status_t'(rd);
  endtask : rd_status

  // Drives the enable pin with a code on the low data bits only.
  task enable(input logic [3:0] code, input logic on);
    dataIn <= {6'h00, code};
    patternGenEnablePin <= on;
  endtask : enable

  // Reset outputs, then a frozen clock keeps the driver off.
  task t_power_up;
    tick(19);
    check("wordOut", 0, wordOut);
    check("serialOutEn_n", 1, serialOutEn_n);
    check("lineFloat", 1, lineFloat);
    check("testOut", 0, testOut);
    @(posedge clk);
    rst_n <= 1'b1;
    tick(5);
    check("serialOutEn_n", 1, serialOutEn_n);
    // The word clock starts only after the supply has long settled.
    clkEn <= 1'b1;
    tick(3);
    check("serialOutEn_n", 0, serialOutEn_n);
    $display("test power_up done");
  endtask : t_power_up

  // Reset value, read-only status and an unmapped address.
  task t_registers;
    apb(REG_CTRL, 1'b0, 32'h0000_0000);
    check("ctrl", CTRL_RESET, rd);
    apb(REG_CTRL, 1'b1, 32'h0000_003C);
    apb(REG_STATUS, 1'b1, 32'hFFFF_FFFF);
    apb(8'h08, 1'b1, 32'hFFFF_FFFF);
    check("pslverr", 1, err);
    apb(8'h08, 1'b0, 32'h0000_0000);
    check("pslverr", 1, err);
    check("unmapped", 0, rd);
    apb(REG_CTRL, 1'b0, 32'h0000_0000);
    check("ctrl", 32'h0000_003C, rd);
    rd_status;
    check("status", 32'h0000_0002, rd);
    apb(REG_CTRL, 1'b1, 32'h0000_0000);
    $display("test registers done");
  endtask : t_registers

  // Enable is refused without lock, taken once lock arrives.
  task t_lock;
    enable(4'h1, 1'b1);
    tick(4);
    check("lockDetect", 0, lockDetect);
    rd_status;
    check("mode", MODE_NORMAL, st.mode);
    pllLocked <= 1'b1;
    tick(2);
    check("lockDetect", 1, lockDetect);
    tick(2);
    rd_status;
    check("mode", MODE_PATTERN, st.mode);
    enable(4'h1, 1'b0);
    tick(3);
    $display("test lock done");
  endtask : t_lock

  // Every code: mode chosen by the code, stream running, clean exit.
  task t_patterns;
    logic [15:0] n0;
    logic [1:0] expMode;
    for (int c = 0; c < 16; c++) begin
      enable(4'(c), 1'b1);
      tick(3);
      rd_status;
      expMode = (c == 3 || c == 5) ? MODE_SELFTEST : MODE_PATTERN;
      check("mode", expMode, st.mode);
      n0 = changeCount;
      tick(16);
      check("stream", 1, changeCount - n0 >= 16'h0008);
      enable(4'(c), 1'b0);
      tick(3);
      rd_status;
      check("mode", MODE_NORMAL, st.mode);
    end
    $display("test patterns done");
  endtask : t_patterns

  // Clean self-test passes after two fields and ends with the enable.
  task t_self_test(input logic [3:0] code);
    int n;
    logic [15:0] n0;
    enable(code, 1'b1);
    tick(2 * FIELD_WORDS - 40);
    check("testOut early", 0, testOut);
    n0 = changeCount;
    n = 0;
    while (testOut !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    check("testOut", 1, testOut);
    check("stream", 1, changeCount != n0);
    rd_status;
    check("mode", MODE_SELFTEST, st.mode);
    check("error", 0, st.selfTestError);
    enable(code, 1'b0);
    tick(3);
    check("testOut", 0, testOut);
    rd_status;
    check("mode", MODE_NORMAL, st.mode);
    $display("test self_test done");
  endtask : t_self_test

  // A lock drop mid-test is an error that holds the result low.
  task t_self_test_error;
    enable(CODE_TEST_BARS, 1'b1);
    tick(60);
    pllLocked <= 1'b0;
    tick(3);
    pllLocked <= 1'b1;
    tick(2 * FIELD_WORDS + 40);
    check("testOut", 0, testOut);
    rd_status;
    check("error", 1, st.selfTestError);
    enable(CODE_TEST_BARS, 1'b0);
    tick(3);
    $display("test self_test_error done");
  endtask : t_self_test_error

  // Out of lock the line holds one level with no transitions.
  task t_out_of_lock;
    logic [15:0] n0;
    enable(4'h2, 1'b1);
    tick(10);
    pllLocked <= 1'b0;
    tick(3);
    check("lockDetect", 0, lockDetect);
    check("level", 1, wordOut === 10'h000 || wordOut === 10'h3FF);
    // The receiver still counts the step into the held level one edge on.
    tick(1);
    n0 = changeCount;
    tick(8);
    check("changes", n0, changeCount);
    pllLocked <= 1'b1;
    enable(4'h2, 1'b0);
    tick(3);
    $display("test out_of_lock done");
  endtask : t_out_of_lock

  // Software enable with the code taken from the control register.
  task t_soft_enable;
    apb(REG_CTRL, 1'b1, {26'h000_0000, CODE_TEST_PLL, 2'b11});
    tick(2);
    rd_status;
    check("mode", MODE_SELFTEST, st.mode);
    apb(REG_CTRL, 1'b1, 32'h0000_0000);
    tick(3);
    rd_status;
    check("mode", MODE_NORMAL, st.mode);
    $display("test soft_enable done");
  endtask : t_soft_enable

  // A second reset mid-pattern clears state and floats the lines.
  task t_mid_reset;
    enable(4'h2, 1'b1);
    apb(REG_CTRL, 1'b1, 32'h0000_003C);
    tick(5);
    rst_n <= 1'b0;
    tick(2);
    check("wordOut", 0, wordOut);
    check("serialOutEn_n", 1, serialOutEn_n);
    check("lockDetect", 0, lockDetect);
    rst_n <= 1'b1;
    enable(4'h2, 1'b0);
    tick(3);
    apb(REG_CTRL, 1'b0, 32'h0000_0000);
    check("ctrl", CTRL_RESET, rd);
    $display("test mid_reset done");
  endtask : t_mid_reset

  task give_verdict;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // The whole run needs under 4000 cycles; a hang stops at 20000.
  initial begin
    tick(20000);
    fails++;
    $display("[FAIL] watchdog expected finish seen hang");
    give_verdict;
  end

  // Main sequence; the clock stays frozen through reset on purpose.
  initial begin
    {clkEn, rst_n, patternGenEnablePin, pllLocked} = 4'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dataIn = 10'h000;
    t_power_up;
    t_registers;
    t_lock;
    t_patterns;
    t_self_test(CODE_TEST_BARS);
    t_self_test(CODE_TEST_PLL);
    t_self_test_error;
    t_out_of_lock;
    t_soft_enable;
    t_mid_reset;
    give_verdict;
  end
endmodule : vpgst_top_tb
